// [hw/edag_map.vh]
// Purpose: constants for the external data address generator
// Assumes: 16-bit external data space, 8-bit core registers
// Notes:   on-chip ram range is a parameter of the block; timing field layout is fixed by the defines here
//
// Contract
// - both addressing forms build the address from register contents, never from an immediate field.
// - the long form uses the full 16-bit data pointer as the address.
// - the data pointer is written and read as separate high and low byte registers.
// - the short form takes the high byte from the page register and the low byte from the chosen index register.
// - on-chip ram accesses need no setup and finish in the core's standard move timing.
// - off-chip accesses last a time set by the timing control value.
// - a configurable option redirects external move writes to program flash.
// - with the option clear every access goes to the external ram space, which is the reset state.
`ifndef EDAG_MAP_VH
`define EDAG_MAP_VH
`define EDAG_PTR_RST     8'h00
`define EDAG_PAGE_RST    8'h00
`define EDAG_TIMING_RST  8'hff
`define EDAG_STD_CYCLES  4'h1
`define EDAG_RAM_BASE    16'h0000
`define EDAG_RAM_LAST    16'h0fff
`define EDAG_TC_LSB      0
`define EDAG_TC_MSB      3
`define EDAG_REG_PTR_HI  2'h0
`define EDAG_REG_PTR_LO  2'h1
`define EDAG_REG_PAGE    2'h2
`define EDAG_REG_TC      2'h3
`endif

// [hw/edag_core.v]
// Purpose: forms external-data addresses and steers them on chip, off chip or to flash
// Assumes: core presents one access request per move; same clock as the core
// Notes:   off-chip duration counted here; pin-level bus timing lives elsewhere
`include "edag_map.vh"

module edag_core #(
    parameter [15:0] RAM_BASE = `EDAG_RAM_BASE,
    parameter [15:0] RAM_LAST = `EDAG_RAM_LAST
) (
    input  wire        clk_in,
    input  wire        rst_b_in,
    input  wire        reg_wr_in,
    input  wire [1:0]  reg_sel_in,
    input  wire [7:0]  reg_wdata_in,
    output reg  [7:0]  reg_rdata_out,
    input  wire        flash_wr_sel_in,
    input  wire [7:0]  first_index_in,
    input  wire [7:0]  second_index_in,
    input  wire        acc_req_in,
    input  wire        acc_long_in,
    input  wire        acc_idx_sel_in,
    input  wire        acc_write_in,
    input  wire [7:0]  acc_wdata_in,
    output wire        acc_busy_out,
    output reg         acc_done_out,
    output reg  [7:0]  acc_rdata_out,
    output reg  [15:0] mem_addr_out,
    output reg  [7:0]  mem_wdata_out,
    output reg         ram_en_out,
    output reg         ext_en_out,
    output reg         flash_en_out,
    output reg         mem_write_out,
    input  wire [7:0]  ram_rdata_in,
    input  wire [7:0]  ext_rdata_in
);
    localparam ST_IDLE = 2'h0;
    localparam ST_STD  = 2'h1;
    localparam ST_EXT  = 2'h2;

    // byte registers and the values they take at the next edge
    reg [7:0]   ptr_high_r;
    reg [7:0]   ptr_high_nxt;
    reg [7:0]   ptr_low_r;
    reg [7:0]   ptr_low_nxt;
    reg [7:0]   page_r;
    reg [7:0]   page_nxt;
    reg [7:0]   timing_r;
    reg [7:0]   timing_nxt;
    reg [7:0]   rdata_nxt;
    // access sequencer and the next values of its outputs
    reg [1:0]   state_r;
    reg [1:0]   state_nxt;
    reg [3:0]   cnt_r;
    reg [3:0]   cnt_nxt;
    reg         sel_ext_r;
    reg         sel_ext_nxt;
    reg         done_nxt;
    reg [7:0]   acc_rdata_nxt;
    reg [15:0]  addr_nxt;
    reg [7:0]   wdata_nxt;
    reg         ram_en_nxt;
    reg         ext_en_nxt;
    reg         flash_en_nxt;
    reg         write_nxt;
    // address path and decode results
    wire [15:0] eff_addr;
    wire        in_ram;
    wire [7:0]  idx_val;
    wire        take;
    wire        last_cycle;
    wire        to_flash;
    wire [3:0]  load_cnt;

    // range check used for every access
    function in_range;
        input [15:0] a;
        begin
            in_range = (a >= RAM_BASE) && (a <= RAM_LAST);
        end
    endfunction

    // write decode, shared by all four byte registers
    function wr_hit;
        input       wr;
        input [1:0] sel;
        input [1:0] code;
        begin
            wr_hit = wr && (sel == code);
        end
    endfunction

    // readback select over the byte registers
    function [7:0] sel_reg;
        input [1:0] sel;
        input [7:0] high;
        input [7:0] low;
        input [7:0] page;
        input [7:0] timing;
        begin
            case (sel)
                `EDAG_REG_PTR_HI: sel_reg = high;
                `EDAG_REG_PTR_LO: sel_reg = low;
                `EDAG_REG_PAGE:   sel_reg = page;
                default:          sel_reg = timing;
            endcase
        end
    endfunction

    // address forms: both come from registers only
    assign idx_val  = acc_idx_sel_in ? second_index_in : first_index_in;
    assign eff_addr = acc_long_in ? {ptr_high_r, ptr_low_r}
                                  : {page_r, idx_val};
    assign in_ram   = in_range(eff_addr);

    // sequencer decodes; a request is taken only while idle
    assign acc_busy_out = (state_r != ST_IDLE);
    assign take         = acc_req_in && (state_r == ST_IDLE);
    assign last_cycle   = (state_r != ST_IDLE) && (cnt_r == 4'h0);
    assign to_flash     = acc_write_in && flash_wr_sel_in;
    // on chip: fixed standard timing; off chip: timing field
    assign load_cnt     = in_ram ? `EDAG_STD_CYCLES - 4'h1
                                 : timing_r[`EDAG_TC_MSB:`EDAG_TC_LSB];

    // byte register next values; untouched unless their own code is written
    always @* begin
        ptr_high_nxt = ptr_high_r;
        ptr_low_nxt  = ptr_low_r;
        page_nxt     = page_r;
        timing_nxt   = timing_r;
        if (wr_hit(reg_wr_in, reg_sel_in, `EDAG_REG_PTR_HI)) begin
            ptr_high_nxt = reg_wdata_in;
        end
        if (wr_hit(reg_wr_in, reg_sel_in, `EDAG_REG_PTR_LO)) begin
            ptr_low_nxt = reg_wdata_in;
        end
        if (wr_hit(reg_wr_in, reg_sel_in, `EDAG_REG_PAGE)) begin
            page_nxt = reg_wdata_in;
        end
        if (wr_hit(reg_wr_in, reg_sel_in, `EDAG_REG_TC)) begin
            timing_nxt = reg_wdata_in;
        end
        // readback taken from next values so a fresh write shows at once
        rdata_nxt = sel_reg(reg_sel_in, ptr_high_nxt, ptr_low_nxt, page_nxt, timing_nxt);
    end

    // byte registers and registered readback
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ptr_high_r    <= `EDAG_PTR_RST;
            ptr_low_r     <= `EDAG_PTR_RST;
            page_r        <= `EDAG_PAGE_RST;
            timing_r      <= `EDAG_TIMING_RST;
            reg_rdata_out <= `EDAG_PTR_RST;
        end else begin
            ptr_high_r    <= ptr_high_nxt;
            ptr_low_r     <= ptr_low_nxt;
            page_r        <= page_nxt;
            timing_r      <= timing_nxt;
            reg_rdata_out <= rdata_nxt;
        end
    end

    // access sequencer state; requests while busy are ignored
    always @* begin
        case (state_r)
            ST_IDLE: state_nxt = acc_req_in ? (in_ram ? ST_STD : ST_EXT) : ST_IDLE;
            ST_STD:  state_nxt = (cnt_r == 4'h0) ? ST_IDLE : ST_STD;
            ST_EXT:  state_nxt = (cnt_r == 4'h0) ? ST_IDLE : ST_EXT;
            default: state_nxt = ST_IDLE;
        endcase
    end

    // access datapath; strobes held for the whole access, done the cycle after the last, as the strobes drop
    always @* begin
        cnt_nxt       = cnt_r;
        sel_ext_nxt   = sel_ext_r;
        done_nxt      = 1'b0;
        acc_rdata_nxt = acc_rdata_out;
        addr_nxt      = mem_addr_out;
        wdata_nxt     = mem_wdata_out;
        ram_en_nxt    = ram_en_out;
        ext_en_nxt    = ext_en_out;
        flash_en_nxt  = flash_en_out;
        write_nxt     = mem_write_out;
        if (take) begin
            addr_nxt    = eff_addr;
            wdata_nxt   = acc_wdata_in;
            write_nxt   = acc_write_in;
            sel_ext_nxt = ~in_ram;
            cnt_nxt     = load_cnt;
            if (to_flash) begin
                flash_en_nxt = 1'b1;
            end else begin
                ram_en_nxt = in_ram;
                ext_en_nxt = ~in_ram;
            end
        end else if (last_cycle) begin
            done_nxt      = 1'b1;
            acc_rdata_nxt = sel_ext_r ? ext_rdata_in : ram_rdata_in;
            ram_en_nxt    = 1'b0;
            ext_en_nxt    = 1'b0;
            flash_en_nxt  = 1'b0;
            write_nxt     = 1'b0;
        end else if (state_r != ST_IDLE) begin
            cnt_nxt = cnt_r - 4'h1;
        end
    end

    // sequencer and output flops, loaded every edge
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_r       <= ST_IDLE;
            cnt_r         <= 4'h0;
            sel_ext_r     <= 1'b0;
            acc_done_out  <= 1'b0;
            acc_rdata_out <= 8'h00;
            mem_addr_out  <= 16'h0000;
            mem_wdata_out <= 8'h00;
            ram_en_out    <= 1'b0;
            ext_en_out    <= 1'b0;
            flash_en_out  <= 1'b0;
            mem_write_out <= 1'b0;
        end else begin
            state_r       <= state_nxt;
            cnt_r         <= cnt_nxt;
            sel_ext_r     <= sel_ext_nxt;
            acc_done_out  <= done_nxt;
            acc_rdata_out <= acc_rdata_nxt;
            mem_addr_out  <= addr_nxt;
            mem_wdata_out <= wdata_nxt;
            ram_en_out    <= ram_en_nxt;
            ext_en_out    <= ext_en_nxt;
            flash_en_out  <= flash_en_nxt;
            mem_write_out <= write_nxt;
        end
    end
endmodule // edag_core

// [verification/edag_mem_model.sv]
// Purpose: memory model behind edag_core, on-chip ram and off-chip side
// Assumes: reads answer at once from the address
// Notes:   a deselected bus shows a running count, never stale data
module edag_mem_model (
    input  wire        clk_in, ram_en_in, ext_en_in,
    input  wire [15:0] addr_in,
    output wire [7:0]  ram_rdata_out, ext_rdata_out
);
    timeunit 1ns;
    timeprecision 1ns;
    reg [7:0] junk_r = 8'h5a;
    // released lines change every cycle so a late sample cannot match
    always @(posedge clk_in) junk_r <= junk_r + 8'h01;
    // off-chip data inverted so a misrouted read shows
    assign ram_rdata_out = ram_en_in ? addr_in[7:0] ^ addr_in[15:8] : junk_r;
    assign ext_rdata_out = ext_en_in ? ~(addr_in[7:0] ^ addr_in[15:8]) : ~junk_r;
endmodule // edag_mem_model

// [verification/edag_checker.sv]
// Purpose: port checks for edag_core
// Assumes: one clock, async active-low reset
// Notes:   pointer contents seen only through readback
module edag_checker #(parameter [15:0] RAM_BASE = 16'h0000, parameter [15:0] RAM_LAST = 16'h0fff) (
    input wire        clk_in, rst_b_in, reg_wr_in, acc_req_in, acc_busy_out, acc_done_out, acc_long_in,
    input wire        acc_idx_sel_in, flash_wr_sel_in, ram_en_out, ext_en_out, flash_en_out, mem_write_out,
    input wire [1:0]  reg_sel_in,
    input wire [7:0]  reg_wdata_in, reg_rdata_out, first_index_in, second_index_in,
    input wire [15:0] mem_addr_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    wire tk = acc_req_in && !acc_busy_out;
    property p_rng; ram_en_out |-> mem_addr_out >= RAM_BASE && mem_addr_out <= RAM_LAST; endproperty
    a_rng: assert property (p_rng) else $error("ram access out of range");
    property p_ext; ext_en_out |-> mem_addr_out < RAM_BASE || mem_addr_out > RAM_LAST; endproperty
    a_ext: assert property (p_ext) else $error("off-chip access in range");
    property p_fl; flash_en_out |-> mem_write_out && !ram_en_out && !ext_en_out; endproperty
    a_fl: assert property (p_fl) else $error("flash target misused");
    property p_def; tk && !flash_wr_sel_in |=> !flash_en_out; endproperty
    a_def: assert property (p_def) else $error("flash without option");
    property p_on; $rose(ram_en_out) |=> acc_done_out; endproperty
    a_on: assert property (p_on) else $error("ram access slow");
    property p_off; $rose(ext_en_out) |-> ##[1:16] acc_done_out; endproperty
    a_off: assert property (p_off) else $error("off-chip access too long");
    property p_idx; tk && !acc_long_in |=> mem_addr_out[7:0] ==
        ($past(acc_idx_sel_in) ? $past(second_index_in) : $past(first_index_in)); endproperty
    a_idx: assert property (p_idx) else $error("short form low byte wrong");
    property p_byte; reg_wr_in && reg_sel_in == 2'h1 ##1 !reg_wr_in && reg_sel_in == 2'h1
        |-> reg_rdata_out == $past(reg_wdata_in); endproperty
    a_byte: assert property (p_byte) else $error("low byte readback wrong");
    c_long: cover property (tk && acc_long_in);
    c_ext: cover property ($rose(ext_en_out));
    c_fl: cover property (flash_en_out);
endmodule // edag_checker
bind edag_core edag_checker #(.RAM_BASE(RAM_BASE), .RAM_LAST(RAM_LAST)) u_chk (.clk_in(clk_in),
    .rst_b_in(rst_b_in), .reg_wr_in(reg_wr_in), .acc_req_in(acc_req_in), .acc_busy_out(acc_busy_out),
    .acc_done_out(acc_done_out), .acc_long_in(acc_long_in), .acc_idx_sel_in(acc_idx_sel_in),
    .flash_wr_sel_in(flash_wr_sel_in), .ram_en_out(ram_en_out), .ext_en_out(ext_en_out),
    .flash_en_out(flash_en_out), .mem_write_out(mem_write_out), .reg_sel_in(reg_sel_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .first_index_in(first_index_in),
    .second_index_in(second_index_in), .mem_addr_out(mem_addr_out));

// [verification/tb.sv]
// Purpose: random self-checking bench for edag_core
// Assumes: memory model answers reads at once
// Notes:   flash latency left open, not compared
`include "edag_map.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    `define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
        $display("FAIL t=%0t got %h exp %h", $time, g, e); end end
    logic clk_in = 0, rst_b_in = 0, reg_wr_in = 0, flash_wr_sel_in = 0, acc_req_in = 0, acc_long_in = 0;
    logic acc_idx_sel_in = 0, acc_write_in = 0, acc_busy_out, acc_done_out, ram_en_out, ext_en_out;
    logic flash_en_out, mem_write_out;
    logic [1:0] reg_sel_in = 0;
    logic [7:0] reg_wdata_in = 0, first_index_in = 0, second_index_in = 0, acc_wdata_in = 0;
    logic [7:0] reg_rdata_out, acc_rdata_out, mem_wdata_out, ram_rdata_in, ext_rdata_in;
    logic [15:0] mem_addr_out;
    logic [40:0] q[$], ob, ex;
    logic [31:0] r;
    logic [3:0] fl_r = 0;
    logic [4:0] cnt = 0;
    int err_count = 0, n_checks = 0, seed = 11419;
    edag_core dut (.*);
    edag_mem_model u_mem (.clk_in, .ram_en_in(ram_en_out), .ext_en_in(ext_en_out), .addr_in(mem_addr_out),
        .ram_rdata_out(ram_rdata_in), .ext_rdata_out(ext_rdata_in));
    initial forever #20 clk_in = ~clk_in;
    // route flags held while enabled, result compared at the done pulse
    always @(posedge clk_in) begin
        if (ram_en_out | ext_en_out | flash_en_out) fl_r <= {flash_en_out, ext_en_out, ram_en_out, mem_write_out};
        cnt <= acc_busy_out ? cnt + 5'h01 : 5'h00;
        if (acc_done_out) begin
            ob = {mem_addr_out, mem_wdata_out, fl_r, fl_r[3] ? 5'h00 : cnt, fl_r[0] ? 8'h00 : acc_rdata_out};
            ex = q.pop_front();
            `CHK(ob, ex)
        end
    end
    task automatic wreg(input [1:0] s, input [7:0] d);
        @(posedge clk_in);
        reg_wr_in <= 1'b1;
        reg_sel_in <= s;
        reg_wdata_in <= d;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
        @(negedge clk_in);
        `CHK(reg_rdata_out, d)
    endtask
    task automatic acc(input [7:0] hi, lo, input lg, ix, wr, fl, input [3:0] tc);
        logic [15:0] a;
        logic [3:0] f;
        a = lg ? {hi, lo} : {hi ^ 8'h01, ix ? ~lo : lo};
        f = (wr && fl) ? 4'h9 : ((a <= `EDAG_RAM_LAST) ? 4'h2 : 4'h4) | {3'h0, wr};
        q.push_back({a, lo, f, f[3] ? 5'h00 : (f[1] ? {1'b0, `EDAG_STD_CYCLES} : {1'b0, tc} + 5'h01),
            wr ? 8'h00 : (f[1] ? a[7:0] ^ a[15:8] : ~(a[7:0] ^ a[15:8]))});
        wreg(2'h0, hi);
        wreg(2'h1, lo);
        wreg(2'h2, hi ^ 8'h01);
        wreg(2'h3, {4'h0, tc});
        @(posedge clk_in);
        {acc_req_in, acc_long_in, acc_idx_sel_in, acc_write_in, flash_wr_sel_in} <= {1'b1, lg, ix, wr, fl};
        {first_index_in, second_index_in, acc_wdata_in} <= {lo, ~lo, lo};
        @(posedge clk_in);
        acc_req_in <= 1'b0;
        repeat (20) @(negedge clk_in) if (acc_done_out) break;
    endtask
    task test_done;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk_in);
        rst_b_in <= 1'b1;
        for (int i = 0; i < 60; i++) begin
            r = $random(seed);
            acc(r[7:0] & 8'h1f, r[15:8], r[16], r[17], r[18], r[19], r[23:20]);
        end
        @(negedge clk_in);
        `CHK(q.size(), 0)
        test_done;
    end
    initial begin
        #200000;
        err_count++;
        test_done;
    end
endmodule // tb
